// ==== verilog/gpio_gh_pkg.sv ====
// package: register map, reset values, field positions and codes for ports g/h
package gpio_gh_pkg;
    // register byte addresses (printed offsets are word aligned)
    localparam logic [31:0] ADDR_G_FSEL   = 32'h5600_0060;
    localparam logic [31:0] ADDR_G_DATA   = 32'h5600_0064;
    localparam logic [31:0] ADDR_G_PULLUP = 32'h5600_0068;
    localparam logic [31:0] ADDR_H_FSEL   = 32'h5600_0070;
    localparam logic [31:0] ADDR_H_DATA   = 32'h5600_0074;
    localparam logic [31:0] ADDR_H_PULLUP = 32'h5600_0078;
    localparam logic [31:0] ADDR_MISC     = 32'h5600_0080;
    // reset values
    localparam logic [31:0] RST_G_FSEL    = 32'h0000_0000;
    localparam logic [15:0] RST_G_PULLUP  = 16'hf800;
    localparam logic [21:0] RST_H_FSEL    = 22'h00_0000;
    localparam logic [10:0] RST_H_PULLUP  = 11'h000;
    localparam logic [31:0] RST_MISC      = 32'h0001_0330;
    // writable bits of the misc register, all others reserved
    localparam logic [31:0] MISC_WMASK    = 32'h000f_377b;
    // misc field positions
    localparam int MISC_MEMORY_CLOCK_ENABLE_PIN_LOW  = 19;
    localparam int MISC_SCLK1_LOW = 18;
    localparam int MISC_SCLK0_LOW = 17;
    localparam int MISC_RSTOUT    = 16;
    localparam int MISC_USB1_SUSP = 13;
    localparam int MISC_USB0_SUSP = 12;
    localparam int MISC_MON1_LSB  = 8;
    localparam int MISC_MON0_LSB  = 4;
    localparam int MISC_USB_PAD   = 3;
    localparam int MISC_DLO_PU    = 1;
    localparam int MISC_DHI_PU    = 0;
    // pin function selector codes
    localparam logic [1:0] FSEL_INPUT  = 2'h0;
    localparam logic [1:0] FSEL_OUTPUT = 2'h1;
    localparam logic [1:0] FSEL_ALT_A  = 2'h2;
    localparam logic [1:0] FSEL_ALT_B  = 2'h3;
    // clock monitor source codes
    typedef enum logic [2:0] {
        MON_MAIN_PLL = 3'h0,
        MON_USB_PLL  = 3'h1,
        MON_CORE     = 3'h2,
        MON_SYS_BUS  = 3'h3,
        MON_PERIPH   = 3'h4,
        MON_DIVIDED  = 3'h5
    } mon_src_t;
    // pad-side control bundle from the misc register
    typedef struct packed {
        logic       memclk_enable_force_low;
        logic       memory_clock1_force_low;
        logic       memory_clock0_force_low;
        logic       reset_out_pin;
        logic       usb_port1_sleep;
        logic       usb_port0_sleep;
        logic       usb_pad_owner;
        logic       data_low_pullup_off;
        logic       data_high_pullup_off;
    } misc_ctrl_t;
    // clock sources offered to the monitor muxes
    typedef struct packed {
        logic main_pll;
        logic usb_pll;
        logic core_clock;
        logic sys_bus_clock;
        logic periph_clock;
        logic divided_clock_1;
        logic divided_clock_0;
    } mon_srcs_t;
endpackage

// ==== verilog/gpio_ports_g_h_misc_control.sv ====
// top: port g/h pin control, misc pad control and clock monitor select
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - port g selector per pin, 00 in 01 out
// - port g code 10 routes interrupt line n+8
// - port g code 11 alternate functions per pin
// - input reads pin, output drives written bit
// - functional pin data reads undefined
// - pullup bit 0 enables, 1 disables
// - port g pullup resets to f800
// - port h 11 selectors, alternate mapping, reset zero
// - port h pullups reset to zero
// - misc bits 19..17 force memory clocks low
// - misc bit 16 sets reset-out level
// - misc bits 13,12 suspend usb ports
// - monitor 1 source select bits 10..8, all three writable, codes 6 and 7 reserved
// - monitor 0 source select bits 6..4
// - misc bit 3 gives usb pads owner
// - misc bits 1,0 data bus pullups off
// - misc resets to 10330, reserved read zero
module gpio_ports_g_h_misc_control #(
    parameter int G_PINS = 16,              // port g width
    parameter int H_PINS = 11               // port h width
) (
    input  wire logic                    CORE_CLK_IN,
    input  wire logic                    RST_IN,
    input  wire logic                    CLK_EN_IN,
    // register port
    input  wire logic [31:0]             ADDR_IN,
    input  wire logic [31:0]             WDATA_IN,
    input  wire logic                    WR_IN,
    input  wire logic                    RD_IN,
    output logic      [31:0]             RDATA_OUT,
    // port g pads
    input  wire logic [G_PINS-1:0]       G_PIN_IN,
    output logic      [G_PINS-1:0]       G_PIN_OUT,
    output logic      [G_PINS-1:0]       G_PIN_OE_OUT,
    output logic      [G_PINS-1:0]       G_PULLUP_EN_OUT,
    // port g functions: interrupt lines 8..23 and alternates
    output logic      [G_PINS-1:0]       G_EXT_IRQ_LINE_OUT,
    output logic      [G_PINS-1:0]       G_ALT_IN_OUT,
    input  wire logic [G_PINS-1:0]       G_ALT_DRIVE_IN,
    input  wire logic [G_PINS-1:0]       G_ALT_OE_IN,
    // port h pads
    input  wire logic [H_PINS-1:0]       H_PIN_IN,
    output logic      [H_PINS-1:0]       H_PIN_OUT,
    output logic      [H_PINS-1:0]       H_PIN_OE_OUT,
    output logic      [H_PINS-1:0]       H_PULLUP_EN_OUT,
    // port h functions: uart, usb clock in, monitor pins
    output logic      [H_PINS-1:0]       H_ALT_IN_OUT,
    input  wire logic [H_PINS-1:0]       H_ALT_DRIVE_IN,
    input  wire logic [H_PINS-1:0]       H_ALT_OE_IN,
    // misc pad controls
    output gpio_gh_pkg::misc_ctrl_t      MISC_CTRL_OUT,
    // clock monitor selection (pulse sampled sources)
    input  wire gpio_gh_pkg::mon_srcs_t  MON_SRCS_IN,
    output logic                         CLOCK_MONITOR_OUT_1_OUT,
    output logic                         CLOCK_MONITOR_OUT_0_OUT
);
    // g alternate-function pins selectable by code 11
    localparam logic [15:0] G_CODE3_OK = 16'hf8fc;
    // h pins with code 11 function: uart1 flow control
    localparam logic [10:0] H_CODE3_OK = 11'h0c0;
    // h pins whose code 10 function is an output pin on the pad
    localparam logic [10:0] H_CODE2_DRV = 11'h657;

    // registers
    logic [2*G_PINS-1:0] g_fsel_reg;     // port g selectors
    logic [G_PINS-1:0]   g_data_reg;     // port g written data
    logic [G_PINS-1:0]   g_pull_reg;     // port g pull-up disable
    logic [2*H_PINS-1:0] h_fsel_reg;     // port h selectors
    logic [H_PINS-1:0]   h_data_reg;     // port h written data
    logic [H_PINS-1:0]   h_pull_reg;     // port h pull-up disable
    logic [31:0]         misc_reg;       // misc pad/clock control
    // pin synchronisers, three stages
    logic [G_PINS-1:0]   g_s1_reg, g_s2_reg, g_s3_reg, g_stable_reg;
    logic [H_PINS-1:0]   h_s1_reg, h_s2_reg, h_s3_reg, h_stable_reg;

    // write decode
    wire wr_g_fsel = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_G_FSEL;
    wire wr_g_data = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_G_DATA;
    wire wr_g_pull = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_G_PULLUP;
    wire wr_h_fsel = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_H_FSEL;
    wire wr_h_data = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_H_DATA;
    wire wr_h_pull = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_H_PULLUP;
    wire wr_misc   = WR_IN && ADDR_IN == gpio_gh_pkg::ADDR_MISC;

    // per-pin mode decode and pad drive
    logic [G_PINS-1:0] g_is_in, g_is_out, g_is_alt, g_oe_next, g_o_next;
    logic [G_PINS-1:0] g_irq_next, g_altin_next;
    logic [H_PINS-1:0] h_is_in, h_is_out, h_is_alt, h_oe_next, h_o_next;
    logic [H_PINS-1:0] h_altin_next;
    logic              mon1_sel, mon0_sel;  // monitor mux results

    genvar gi;
    generate
        for (gi = 0; gi < G_PINS; gi++) begin : g_pin
            wire [1:0] code = g_fsel_reg[2*gi +: 2];
            // reserved code 11 falls back to input
            assign g_is_out[gi] = code == gpio_gh_pkg::FSEL_OUTPUT;
            assign g_is_alt[gi] = code == gpio_gh_pkg::FSEL_ALT_B
                                  && G_CODE3_OK[gi];
            assign g_is_in[gi]  = code == gpio_gh_pkg::FSEL_INPUT;
            // code 10: pin feeds interrupt line gi+8
            assign g_irq_next[gi] = code == gpio_gh_pkg::FSEL_ALT_A
                                    && g_stable_reg[gi];
            assign g_altin_next[gi] = g_is_alt[gi] && g_stable_reg[gi];
            // output drives written bit, alternate drives peer
            assign g_oe_next[gi] = g_is_out[gi]
                                   || (g_is_alt[gi] && G_ALT_OE_IN[gi]);
            assign g_o_next[gi]  = g_is_out[gi] ? g_data_reg[gi]
                                   : G_ALT_DRIVE_IN[gi];
        end
        for (gi = 0; gi < H_PINS; gi++) begin : h_pin
            wire [1:0] code = h_fsel_reg[2*gi +: 2];
            wire alt2 = code == gpio_gh_pkg::FSEL_ALT_A;
            wire alt3 = code == gpio_gh_pkg::FSEL_ALT_B && H_CODE3_OK[gi];
            assign h_is_out[gi] = code == gpio_gh_pkg::FSEL_OUTPUT;
            assign h_is_alt[gi] = alt2 || alt3;
            assign h_is_in[gi]  = code == gpio_gh_pkg::FSEL_INPUT;
            assign h_altin_next[gi] = h_is_alt[gi] && h_stable_reg[gi];
            // monitor pins are driven by this block, see below
            assign h_oe_next[gi] = h_is_out[gi] || (alt2 && H_CODE2_DRV[gi]
                                   && (gi >= 9 || H_ALT_OE_IN[gi]))
                                   || (alt3 && H_ALT_OE_IN[gi]);
            assign h_o_next[gi] = h_is_out[gi] ? h_data_reg[gi]
                                : (alt2 && gi == 10) ? mon1_sel
                                : (alt2 && gi == 9)  ? mon0_sel
                                : H_ALT_DRIVE_IN[gi];
        end
    endgenerate

    // clock monitor muxes; observation only, not for clocking
    wire [2:0] mon1_code = misc_reg[gpio_gh_pkg::MISC_MON1_LSB +: 3];
    wire [2:0] mon0_code = misc_reg[gpio_gh_pkg::MISC_MON0_LSB +: 3];
    always_comb begin
        unique case (mon1_code)
            gpio_gh_pkg::MON_MAIN_PLL: mon1_sel = MON_SRCS_IN.main_pll;
            gpio_gh_pkg::MON_USB_PLL:  mon1_sel = MON_SRCS_IN.usb_pll;
            gpio_gh_pkg::MON_CORE:     mon1_sel = MON_SRCS_IN.core_clock;
            gpio_gh_pkg::MON_SYS_BUS:  mon1_sel = MON_SRCS_IN.sys_bus_clock;
            gpio_gh_pkg::MON_PERIPH:   mon1_sel = MON_SRCS_IN.periph_clock;
            gpio_gh_pkg::MON_DIVIDED:  mon1_sel = MON_SRCS_IN.divided_clock_1;
            default:                   mon1_sel = 1'b0;  // reserved 11x
        endcase
        unique case (mon0_code)
            gpio_gh_pkg::MON_MAIN_PLL: mon0_sel = MON_SRCS_IN.main_pll;
            gpio_gh_pkg::MON_USB_PLL:  mon0_sel = MON_SRCS_IN.usb_pll;
            gpio_gh_pkg::MON_CORE:     mon0_sel = MON_SRCS_IN.core_clock;
            gpio_gh_pkg::MON_SYS_BUS:  mon0_sel = MON_SRCS_IN.sys_bus_clock;
            gpio_gh_pkg::MON_PERIPH:   mon0_sel = MON_SRCS_IN.periph_clock;
            gpio_gh_pkg::MON_DIVIDED:  mon0_sel = MON_SRCS_IN.divided_clock_0;
            default:                   mon0_sel = 1'b0;  // reserved 11x
        endcase
    end

    // data reads: pin level in input mode, latch in output mode
    // functional pins read the pin too; software must not rely on it
    wire [G_PINS-1:0] g_rd = (g_is_out & g_data_reg)
                           | (~g_is_out & g_stable_reg);
    wire [H_PINS-1:0] h_rd = (h_is_out & h_data_reg)
                           | (~h_is_out & h_stable_reg);

    // read mux; unmapped addresses and reserved bits read zero
    logic [31:0] rdata_next;
    always_comb begin
        unique case (ADDR_IN)
            gpio_gh_pkg::ADDR_G_FSEL:   rdata_next = 32'(g_fsel_reg);
            gpio_gh_pkg::ADDR_G_DATA:   rdata_next = 32'(g_rd);
            gpio_gh_pkg::ADDR_G_PULLUP: rdata_next = 32'(g_pull_reg);
            gpio_gh_pkg::ADDR_H_FSEL:   rdata_next = 32'(h_fsel_reg);
            gpio_gh_pkg::ADDR_H_DATA:   rdata_next = 32'(h_rd);
            gpio_gh_pkg::ADDR_H_PULLUP: rdata_next = 32'(h_pull_reg);
            gpio_gh_pkg::ADDR_MISC:     rdata_next = misc_reg;
            default:                    rdata_next = 32'h0000_0000;
        endcase
        if (!RD_IN) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // misc pad bundle from register bits
    gpio_gh_pkg::misc_ctrl_t misc_next;
    always_comb begin
        misc_next.memclk_enable_force_low =
            misc_reg[gpio_gh_pkg::MISC_MEMORY_CLOCK_ENABLE_PIN_LOW];
        misc_next.memory_clock1_force_low =
            misc_reg[gpio_gh_pkg::MISC_SCLK1_LOW];
        misc_next.memory_clock0_force_low =
            misc_reg[gpio_gh_pkg::MISC_SCLK0_LOW];
        misc_next.reset_out_pin =
            misc_reg[gpio_gh_pkg::MISC_RSTOUT];
        misc_next.usb_port1_sleep =
            misc_reg[gpio_gh_pkg::MISC_USB1_SUSP];
        misc_next.usb_port0_sleep =
            misc_reg[gpio_gh_pkg::MISC_USB0_SUSP];
        misc_next.usb_pad_owner =
            misc_reg[gpio_gh_pkg::MISC_USB_PAD];
        misc_next.data_low_pullup_off =
            misc_reg[gpio_gh_pkg::MISC_DLO_PU];
        misc_next.data_high_pullup_off =
            misc_reg[gpio_gh_pkg::MISC_DHI_PU];
    end

    // pin synchronisers: a change counts once stages two and three agree
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            g_s1_reg <= '0; g_s2_reg <= '0; g_s3_reg <= '0; g_stable_reg <= '0;
            h_s1_reg <= '0; h_s2_reg <= '0; h_s3_reg <= '0; h_stable_reg <= '0;
        end else if (CLK_EN_IN) begin
            g_s1_reg <= G_PIN_IN;
            g_s2_reg <= g_s1_reg;
            g_s3_reg <= g_s2_reg;
            g_stable_reg <= (g_s2_reg & g_s3_reg)
                          | (g_stable_reg & (g_s2_reg | g_s3_reg));
            h_s1_reg <= H_PIN_IN;
            h_s2_reg <= h_s1_reg;
            h_s3_reg <= h_s2_reg;
            h_stable_reg <= (h_s2_reg & h_s3_reg)
                          | (h_stable_reg & (h_s2_reg | h_s3_reg));
        end
    end

    // register writes; data latches start low as a defined value
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            g_fsel_reg <= gpio_gh_pkg::RST_G_FSEL;
            g_data_reg <= '0;
            g_pull_reg <= gpio_gh_pkg::RST_G_PULLUP;
            h_fsel_reg <= gpio_gh_pkg::RST_H_FSEL;
            h_data_reg <= '0;
            h_pull_reg <= gpio_gh_pkg::RST_H_PULLUP;
            misc_reg   <= gpio_gh_pkg::RST_MISC;
        end else if (CLK_EN_IN) begin
            if (wr_g_fsel) g_fsel_reg <= WDATA_IN[2*G_PINS-1:0];
            if (wr_g_data) g_data_reg <= WDATA_IN[G_PINS-1:0];
            if (wr_g_pull) g_pull_reg <= WDATA_IN[G_PINS-1:0];
            if (wr_h_fsel) h_fsel_reg <= WDATA_IN[2*H_PINS-1:0];
            if (wr_h_data) h_data_reg <= WDATA_IN[H_PINS-1:0];
            if (wr_h_pull) h_pull_reg <= WDATA_IN[H_PINS-1:0];
            if (wr_misc) begin
                misc_reg <= WDATA_IN & gpio_gh_pkg::MISC_WMASK;
            end
        end
    end

    // registered outputs
    always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= '0;
            G_PIN_OUT <= '0; G_PIN_OE_OUT <= '0; G_PULLUP_EN_OUT <= '0;
            G_EXT_IRQ_LINE_OUT <= '0; G_ALT_IN_OUT <= '0;
            H_PIN_OUT <= '0; H_PIN_OE_OUT <= '0; H_PULLUP_EN_OUT <= '0;
            H_ALT_IN_OUT <= '0;
            MISC_CTRL_OUT <= '0;
            CLOCK_MONITOR_OUT_1_OUT <= 1'b0;
            CLOCK_MONITOR_OUT_0_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            RDATA_OUT <= rdata_next;
            G_PIN_OUT <= g_o_next;
            G_PIN_OE_OUT <= g_oe_next;
            G_PULLUP_EN_OUT <= ~g_pull_reg;
            G_EXT_IRQ_LINE_OUT <= g_irq_next;
            G_ALT_IN_OUT <= g_altin_next;
            H_PIN_OUT <= h_o_next;
            H_PIN_OE_OUT <= h_oe_next;
            H_PULLUP_EN_OUT <= ~h_pull_reg;
            H_ALT_IN_OUT <= h_altin_next;
            MISC_CTRL_OUT <= misc_next;
            CLOCK_MONITOR_OUT_1_OUT <= mon1_sel;
            CLOCK_MONITOR_OUT_0_OUT <= mon0_sel;
        end
    end
endmodule

`default_nettype wire

// ==== verif/gpio_gh_sva.sv ====
// checker: bus, pad and clock monitor relations of the g/h port block
`timescale 1ns/1ps
`default_nettype none
module gpio_gh_sva #(
    parameter int G_PINS = 16, // port g width
    parameter int H_PINS = 11  // port h width
) (
    input wire logic                   CORE_CLK_IN,
    input wire logic                   RST_IN,
    input wire logic                   CLK_EN_IN,
    input wire logic [31:0]            ADDR_IN,
    input wire logic [31:0]            WDATA_IN,
    input wire logic                   WR_IN,
    input wire logic                   RD_IN,
    input wire logic [31:0]            RDATA_OUT,
    input wire logic [G_PINS-1:0]      G_PIN_OE_OUT,
    input wire logic [G_PINS-1:0]      G_PULLUP_EN_OUT,
    input wire logic [G_PINS-1:0]      G_EXT_IRQ_LINE_OUT,
    input wire gpio_gh_pkg::misc_ctrl_t MISC_CTRL_OUT,
    input wire gpio_gh_pkg::mon_srcs_t  MON_SRCS_IN,
    input wire logic                   CLOCK_MONITOR_OUT_1_OUT,
    input wire logic                   CLOCK_MONITOR_OUT_0_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    logic [G_PINS-1:0] out_mask; // pins coded as output in write data
    logic              io_only;  // no pin coded as a function
    logic              mapped;   // address hits a register
    logic [8:0]        mbits;    // write data bits that reach the pads
    logic              wr_on;    // write taken this edge
    assign wr_on = WR_IN && CLK_EN_IN;
    assign mapped = ADDR_IN inside {gpio_gh_pkg::ADDR_G_FSEL,
        gpio_gh_pkg::ADDR_G_DATA, gpio_gh_pkg::ADDR_G_PULLUP,
        gpio_gh_pkg::ADDR_H_FSEL, gpio_gh_pkg::ADDR_H_DATA,
        gpio_gh_pkg::ADDR_H_PULLUP, gpio_gh_pkg::ADDR_MISC};
    assign mbits = {WDATA_IN[19:16], WDATA_IN[13:12], WDATA_IN[3],
                    WDATA_IN[1:0]};
    // decode selector codes of the word being written
    always_comb begin
        io_only = 1'b1;
        for (int i = 0; i < G_PINS; i++) begin
            out_mask[i] = WDATA_IN[2*i +: 2] == 2'h1;
            if (WDATA_IN[2*i+1]) io_only = 1'b0;
        end
    end
    a_hole_reads_zero: assert property (
        $past(RD_IN && CLK_EN_IN && !mapped) |-> RDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_misc_rsvd_zero: assert property (
        $past(RD_IN && CLK_EN_IN && ADDR_IN == gpio_gh_pkg::ADDR_MISC)
        |-> (RDATA_OUT & ~gpio_gh_pkg::MISC_WMASK) == 32'h0)
        else $error("misc reserved bits read set");
    a_pullup_follows: assert property (
        wr_on && ADDR_IN == gpio_gh_pkg::ADDR_G_PULLUP ##1 !WR_IN
        |=> G_PULLUP_EN_OUT == ~$past(WDATA_IN[G_PINS-1:0], 2))
        else $error("pullup enable not inverse of written bits");
    a_misc_pads: assert property (
        wr_on && ADDR_IN == gpio_gh_pkg::ADDR_MISC ##1 !WR_IN
        |=> MISC_CTRL_OUT == $past(mbits, 2))
        else $error("misc pad controls differ from written bits");
    a_output_enable: assert property (
        wr_on && ADDR_IN == gpio_gh_pkg::ADDR_G_FSEL && io_only ##1 !WR_IN
        |=> G_PIN_OE_OUT == $past(out_mask, 2))
        else $error("output enables differ from output codes");
    a_irq_undriven: assert property (
        (G_EXT_IRQ_LINE_OUT & G_PIN_OE_OUT) == '0)
        else $error("interrupt pin also driven");
    a_mon1_reserved: assert property (
        wr_on && ADDR_IN == gpio_gh_pkg::ADDR_MISC
        && WDATA_IN[10:9] == 2'h3 ##1 !WR_IN |=> !CLOCK_MONITOR_OUT_1_OUT)
        else $error("monitor 1 active on reserved code");
    a_mon0_divided: assert property (
        wr_on && ADDR_IN == gpio_gh_pkg::ADDR_MISC
        && WDATA_IN[6:4] == 3'h5 ##1 !WR_IN
        |=> CLOCK_MONITOR_OUT_0_OUT == $past(MON_SRCS_IN.divided_clock_0))
        else $error("monitor 0 not on divided clock 0");
endmodule
bind gpio_ports_g_h_misc_control gpio_gh_sva #(.G_PINS(G_PINS),
    .H_PINS(H_PINS)) sva (.CORE_CLK_IN, .RST_IN, .CLK_EN_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .G_PIN_OE_OUT, .G_PULLUP_EN_OUT,
    .G_EXT_IRQ_LINE_OUT, .MISC_CTRL_OUT, .MON_SRCS_IN,
    .CLOCK_MONITOR_OUT_1_OUT, .CLOCK_MONITOR_OUT_0_OUT);
`default_nettype wire

// ==== verif/pad_peer.sv ====
// partner: board pads and on-chip peripheral at one port
`timescale 1ns/1ps
`default_nettype none
module pad_peer #(
    parameter int W = 16 // pins in the port
) (
    input  wire logic [W-1:0] pin_out,   // block drive level
    input  wire logic [W-1:0] pin_oe,    // block drives when high
    input  wire logic [W-1:0] ext_level, // board level, weak
    input  wire logic [W-1:0] alt_val,   // peripheral output level
    input  wire logic [W-1:0] alt_en,    // peripheral output enable
    output logic      [W-1:0] pin_in,    // resolved pad level
    output logic      [W-1:0] alt_drive, // to block function input
    output logic      [W-1:0] alt_oe     // to block function enable
);
    // board level is weak, so the block's drive wins where enabled
    assign pin_in    = (pin_oe & pin_out) | (~pin_oe & ext_level);
    assign alt_drive = alt_val;
    assign alt_oe    = alt_en;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// testbench: register, pad, function select and clock monitor scenarios
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0;   // 40 MHz core clock
    logic        rst = 1'b1;   // held for 4 cycles
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
    logic        wr = 1'b0, rd = 1'b0, mon1, mon0;
    logic [15:0] g_out, g_oe, g_pu, g_irq, g_ain, g_in, g_adrv, g_aoe;
    logic [15:0] g_ext = 16'h0, g_aval = 16'h0, g_aen = 16'h0;
    logic [10:0] h_out, h_oe, h_pu, h_ain, h_in, h_adrv, h_aoe;
    logic [10:0] h_ext = 11'h0, h_aval = 11'h0, h_aen = 11'h0;
    gpio_gh_pkg::misc_ctrl_t misc;
    gpio_gh_pkg::mon_srcs_t  srcs = 7'h0;
    int          err_count = 0, check_count = 0, cycles = 0;
    always #12.5 clk = ~clk;
    gpio_ports_g_h_misc_control dut (.CORE_CLK_IN(clk), .RST_IN(rst),
        .CLK_EN_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .G_PIN_IN(g_in), .G_PIN_OUT(g_out),
        .G_PIN_OE_OUT(g_oe), .G_PULLUP_EN_OUT(g_pu),
        .G_EXT_IRQ_LINE_OUT(g_irq), .G_ALT_IN_OUT(g_ain),
        .G_ALT_DRIVE_IN(g_adrv), .G_ALT_OE_IN(g_aoe), .H_PIN_IN(h_in),
        .H_PIN_OUT(h_out), .H_PIN_OE_OUT(h_oe), .H_PULLUP_EN_OUT(h_pu),
        .H_ALT_IN_OUT(h_ain), .H_ALT_DRIVE_IN(h_adrv), .H_ALT_OE_IN(h_aoe),
        .MISC_CTRL_OUT(misc), .MON_SRCS_IN(srcs),
        .CLOCK_MONITOR_OUT_1_OUT(mon1), .CLOCK_MONITOR_OUT_0_OUT(mon0));
    pad_peer #(.W(16)) g_peer (.pin_out(g_out), .pin_oe(g_oe),
        .ext_level(g_ext), .alt_val(g_aval), .alt_en(g_aen),
        .pin_in(g_in), .alt_drive(g_adrv), .alt_oe(g_aoe));
    pad_peer #(.W(11)) h_peer (.pin_out(h_out), .pin_oe(h_oe),
        .ext_level(h_ext), .alt_val(h_aval), .alt_en(h_aen),
        .pin_in(h_in), .alt_drive(h_adrv), .alt_oe(h_aoe));
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe; the edge after it is left quiet
    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data is valid only in the cycle after the strobe
    task automatic rreg(input logic [31:0] a, input logic [31:0] exp,
                        input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    // covers the two-cycle pad lag and the input synchroniser
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        rreg(gpio_gh_pkg::ADDR_G_FSEL, 32'h0, "g fsel");
        rreg(gpio_gh_pkg::ADDR_G_PULLUP, 32'hf800, "g pullup");
        rreg(gpio_gh_pkg::ADDR_H_FSEL, 32'h0, "h fsel");
        rreg(gpio_gh_pkg::ADDR_H_PULLUP, 32'h0, "h pullup");
        rreg(gpio_gh_pkg::ADDR_MISC, 32'h0001_0330, "misc");
        chk("g pullup en", 32'h07ff, 32'(g_pu));
        chk("h pullup en", 32'h07ff, 32'(h_pu));
        chk("misc ctrl", 32'h020, 32'(misc));
        $display("test reset values done");
    endtask
    task automatic t_misc();
        wreg(32'h5600_006c, 32'hffff_ffff);
        rreg(32'h5600_006c, 32'h0, "hole");
        wreg(gpio_gh_pkg::ADDR_MISC, 32'hffff_ffff);
        settle();
        chk("misc ctrl", 32'h1ff, 32'(misc));
        rreg(gpio_gh_pkg::ADDR_MISC, 32'h000f_377b, "misc");
        wreg(gpio_gh_pkg::ADDR_MISC, 32'h0);
        settle();
        chk("misc ctrl", 32'h0, 32'(misc));
        $display("test misc control done");
    endtask
    task automatic t_pins();
        wreg(gpio_gh_pkg::ADDR_G_FSEL, 32'h5555_5555);
        wreg(gpio_gh_pkg::ADDR_G_DATA, 32'h0000_a5c3);
        wreg(gpio_gh_pkg::ADDR_H_FSEL, 32'h0015_5555);
        wreg(gpio_gh_pkg::ADDR_H_DATA, 32'h0000_05a3);
        settle();
        chk("g oe", 32'hffff, 32'(g_oe));
        chk("g out", 32'ha5c3, 32'(g_out));
        chk("h out", 32'h05a3, 32'(h_out));
        g_ext <= 16'h3c96;
        h_ext <= 11'h6a5;
        wreg(gpio_gh_pkg::ADDR_G_FSEL, 32'h0);
        wreg(gpio_gh_pkg::ADDR_H_FSEL, 32'h0);
        settle();
        chk("g oe", 32'h0, 32'(g_oe));
        rreg(gpio_gh_pkg::ADDR_G_DATA, 32'h3c96, "g data");
        rreg(gpio_gh_pkg::ADDR_H_DATA, 32'h06a5, "h data");
        $display("test pin data done");
    endtask
    task automatic t_func();
        // wake-up pins 7..0 in interrupt mode as well
        wreg(gpio_gh_pkg::ADDR_G_FSEL, 32'haaaa_aaaa);
        g_ext <= 16'h1234;
        settle();
        chk("irq lines", 32'h1234, 32'(g_irq));
        chk("g oe", 32'h0, 32'(g_oe));
        g_aval <= 16'h5a5a;
        g_aen <= 16'hffff;
        h_aen <= 11'h7ff;
        h_aval <= 11'h0c0;
        wreg(gpio_gh_pkg::ADDR_G_FSEL, 32'hffff_ffff);
        wreg(gpio_gh_pkg::ADDR_H_FSEL, 32'h003f_ffff);
        settle();
        chk("g alt oe", 32'hf8fc, 32'(g_oe));
        chk("g alt out", 32'h5858, 32'(g_out & 16'hf8fc));
        chk("g alt in", 32'h5858, 32'(g_ain));
        chk("h alt oe", 32'h00c0, 32'(h_oe));
        chk("h alt in", 32'h00c0, 32'(h_ain));
        $display("test pin functions done");
    endtask
    task automatic t_pullup();
        wreg(gpio_gh_pkg::ADDR_G_PULLUP, 32'h0000_00ff);
        wreg(gpio_gh_pkg::ADDR_H_PULLUP, 32'hffff_ffff);
        settle();
        chk("g pullup en", 32'hff00, 32'(g_pu));
        chk("h pullup en", 32'h0, 32'(h_pu));
        rreg(gpio_gh_pkg::ADDR_H_PULLUP, 32'h07ff, "h pullup");
        $display("test pullups done");
    endtask
    // only the selected source is high, for code 5 only monitor 1's (divided clock 0 stays low); reserved codes see all high
    // monitors are sampled as levels here, never used as clocks
    task automatic t_mon();
        for (int c = 0; c < 8; c++) begin
            srcs <= (c < 5) ? 7'h40 >> c : (c == 5) ? 7'h02 : 7'h7f;
            wreg(gpio_gh_pkg::ADDR_MISC, (32'(c) << 8) | (32'(c) << 4));
            settle();
            chk("monitor 1", 32'(c < 6), 32'(mon1));
            chk("monitor 0", 32'(c < 5), 32'(mon0));
        end
        srcs <= 7'h01;
        wreg(gpio_gh_pkg::ADDR_H_FSEL, 32'h0028_0000);
        wreg(gpio_gh_pkg::ADDR_MISC, 32'h0000_0550);
        settle();
        chk("monitor 0", 32'h1, 32'(mon0));
        chk("monitor 1", 32'h0, 32'(mon1));
        chk("h monitor oe", 32'h0600, 32'(h_oe));
        chk("h monitor out", 32'h0200, 32'(h_out & 11'h600));
        $display("test clock monitor done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // run should take about 170 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            $display("[FAIL] run cycles expected 4999 seen %0d", cycles);
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_misc();
        t_pins();
        t_func();
        t_pullup();
        t_mon();
        finish_test();
    end
endmodule
`default_nettype wire
